//--- core/ts_params.svh
`ifndef TS_PARAMS_SVH
`define TS_PARAMS_SVH

// system clock
`define TS_CLK_HZ           50000000
// conversion schedule, in milliseconds
`define TS_CONV_PERIOD_MS   100
`define TS_CONV_TIME_MS     10
// sda stuck-low time-out, least legal figure taken
`define TS_TIMEOUT_MS       75
// derived cycle counts, products sized to 64 bits
`define TS_CONV_PERIOD_CYC  ((64'd`TS_CONV_PERIOD_MS * 64'd`TS_CLK_HZ) / 64'd1000)
`define TS_CONV_TIME_CYC    ((64'd`TS_CONV_TIME_MS * 64'd`TS_CLK_HZ) / 64'd1000)
`define TS_TIMEOUT_CYC      ((64'd`TS_TIMEOUT_MS * 64'd`TS_CLK_HZ + 64'd999) / 64'd1000)
// bus target address and byte layout
`define TS_DEV_ADDR         7'h2a
`define TS_TEMP_W           11
`define TS_LSB_PAD_W        5

`endif

//--- core/ts_pkg.sv
package ts_pkg;
    typedef enum logic [2:0] {
        TS_IDLE,
        TS_ADDR,
        TS_DACK,
        TS_WR,
        TS_RD,
        TS_HACK
    } ts_bus_state_e;

    typedef logic [7:0] ts_byte_t;
endpackage

//--- core/ts_conv_if.sv
`timescale 1ns/1ps
interface ts_conv_if;
    logic run;
    logic start;
    logic busy;
    logic done;

    modport ctrl  (output run, input start, input busy, input done);
    modport sched (input run, output start, output busy, output done);
endinterface

//--- core/ts_conv_sched.sv
`timescale 1ns/1ps
`include "ts_params.svh"
module ts_conv_sched #(
    parameter int unsigned PERIOD_CYC = 32'(`TS_CONV_PERIOD_CYC),
    parameter int unsigned CONV_CYC   = 32'(`TS_CONV_TIME_CYC)
) (
    input  wire logic     clock,
    input  wire logic     rst_n,
    ts_conv_if.sched      conv
);
    logic [31:0] cnt_q;

    // period counter; held at zero while stopped so a restart converts at once
    always_ff @(posedge clock) begin
        if (!rst_n || !conv.run) begin
            cnt_q <= 32'h0;
        end else if (cnt_q == PERIOD_CYC - 1) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    // start at period head, busy for the conversion time, idle for the rest
    always_ff @(posedge clock) begin
        if (!rst_n || !conv.run) begin
            conv.start <= 1'b0;
            conv.busy  <= 1'b0;
            conv.done  <= 1'b0;
        end else begin
            conv.start <= (cnt_q == 32'h0);
            conv.done  <= conv.busy && (cnt_q == CONV_CYC);
            if (cnt_q == 32'h0) begin
                conv.busy <= 1'b1;
            end else if (cnt_q == CONV_CYC) begin
                conv.busy <= 1'b0;                           // idle, saves power
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_start_busy;
        conv.start |-> conv.busy && $past(cnt_q) == 32'h0;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not aligned to period head");

    property p_done_time;
        conv.done |-> !conv.busy && $past(cnt_q) == CONV_CYC;
    endproperty
    a_done_time: assert property (p_done_time) else $error("conversion length wrong");

    property p_stop;
        !conv.run |=> !conv.start && !conv.busy;
    endproperty
    a_stop: assert property (p_stop) else $error("conversion while stopped");
endmodule

//--- core/ts_sensor.sv
`timescale 1ns/1ps
`include "ts_params.svh"
module ts_sensor #(
    parameter int unsigned PERIOD_CYC  = 32'(`TS_CONV_PERIOD_CYC),
    parameter int unsigned CONV_CYC    = 32'(`TS_CONV_TIME_CYC),
    parameter int unsigned TIMEOUT_CYC = 32'(`TS_TIMEOUT_CYC)
) (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    output logic                         sda_o,
    output logic                         sda_oe,
    input  wire logic                    shutdown,
    input  wire logic                    alert_mode_select,
    input  wire logic                    alert_polarity,
    input  wire logic [`TS_TEMP_W-1:0]   temp_sample,
    input  wire logic                    trip_level,
    input  wire logic                    limit_cross,
    output logic                         conv_active,
    output logic [`TS_TEMP_W-1:0]        temp_reading,
    output logic                         over_temp_alert_output,
    output logic                         over_temp_alert_oe
);
    ts_conv_if conv ();
    ts_pkg::ts_bus_state_e st_q;
    logic [2:0]  scl_s_q, sda_s_q;
    logic        scl_f_q, sda_f_q, scl_p_q, sda_p_q;
    logic        scl_rise, scl_fall, start_w, stop_w;
    logic [3:0]  bit_cnt_q;
    ts_pkg::ts_byte_t rx_q, tx_q, nxt_w;
    logic        rw_q, lsb_next_q, host_ack_q, rd_hit_q;
    logic [31:0] low_cnt_q;
    logic        timeout_w;
    logic        shdn_p_q, shdn_rise_w, alert_q, alert_d;

    ts_conv_sched #(.PERIOD_CYC(PERIOD_CYC), .CONV_CYC(CONV_CYC)) u_sched (
        .clock (clock),
        .rst_n (rst_n),
        .conv  (conv)
    );
    assign conv.run = !shutdown;

    // pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
            if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end

    // bus events on the filtered lines
    assign scl_rise = scl_f_q && !scl_p_q;
    assign scl_fall = !scl_f_q && scl_p_q;
    assign start_w  = scl_f_q && scl_p_q && !sda_f_q && sda_p_q;
    assign stop_w   = scl_f_q && scl_p_q && sda_f_q && !sda_p_q;

    // stuck-low watch; host slower than 20 hz would trip it falsely
    always_ff @(posedge clock) begin
        if (!rst_n || sda_f_q) begin
            low_cnt_q <= 32'h0;
        end else if (low_cnt_q != TIMEOUT_CYC) begin
            low_cnt_q <= low_cnt_q + 32'h1;
        end
    end
    assign timeout_w = !sda_f_q && (low_cnt_q == TIMEOUT_CYC - 1);

    // bus target; sda is only pulled for our ack and for zero data bits
    always_ff @(posedge clock) begin
        if (!rst_n || timeout_w) begin
            st_q   <= ts_pkg::TS_IDLE;
            sda_oe <= 1'b0;
        end else if (stop_w) begin
            st_q   <= ts_pkg::TS_IDLE;
            sda_oe <= 1'b0;
        end else if (start_w) begin
            st_q   <= ts_pkg::TS_ADDR;
            sda_oe <= 1'b0;
        end else begin
            unique case (st_q)
                ts_pkg::TS_IDLE: ;
                ts_pkg::TS_ADDR, ts_pkg::TS_WR: begin
                    if (scl_fall && bit_cnt_q == 4'h8) begin
                        if (st_q == ts_pkg::TS_WR || rx_q[7:1] == `TS_DEV_ADDR) begin
                            st_q   <= ts_pkg::TS_DACK;
                            sda_oe <= 1'b1;
                        end else begin
                            st_q <= ts_pkg::TS_IDLE;
                        end
                    end
                end
                ts_pkg::TS_DACK: begin
                    if (scl_fall) begin
                        st_q   <= rw_q ? ts_pkg::TS_RD : ts_pkg::TS_WR;
                        sda_oe <= rw_q && !tx_q[7];
                    end
                end
                ts_pkg::TS_RD: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == 4'h8) begin
                            st_q   <= ts_pkg::TS_HACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sda_oe <= !tx_q[6];                  // tx_q shifts on this edge
                        end
                    end
                end
                ts_pkg::TS_HACK: begin
                    if (scl_fall) begin
                        // host nack: stay off the line whatever the next bit
                        st_q   <= host_ack_q ? ts_pkg::TS_RD : ts_pkg::TS_IDLE;
                        sda_oe <= host_ack_q && !nxt_w[7];
                    end
                end
            endcase
        end
    end

    // byte after a host ack; tx_q is stale then, so the pin must look here
    assign nxt_w = lsb_next_q ? {temp_reading[2:0], `TS_LSB_PAD_W'h0} : temp_reading[`TS_TEMP_W-1:3];

    // bit counting, shifting and the byte that goes out next
    always_ff @(posedge clock) begin
        if (!rst_n || start_w) begin
            bit_cnt_q  <= 4'h0;
            rx_q       <= 8'h00;
            tx_q       <= 8'h00;
            rw_q       <= 1'b0;
            lsb_next_q <= 1'b0;
            host_ack_q <= 1'b0;
        end else begin
            if (scl_rise && (st_q == ts_pkg::TS_ADDR || st_q == ts_pkg::TS_WR)) begin
                rx_q      <= {rx_q[6:0], sda_f_q};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (scl_rise && st_q == ts_pkg::TS_RD) bit_cnt_q <= bit_cnt_q + 4'h1;
            if (scl_rise && st_q == ts_pkg::TS_HACK) host_ack_q <= !sda_f_q;
            if (scl_fall && st_q == ts_pkg::TS_ADDR && bit_cnt_q == 4'h8) begin
                rw_q       <= rx_q[0];
                tx_q       <= temp_reading[`TS_TEMP_W-1:3];
                lsb_next_q <= 1'b1;
            end
            if (scl_fall && st_q == ts_pkg::TS_DACK) bit_cnt_q <= 4'h0;
            if (scl_fall && st_q == ts_pkg::TS_RD && bit_cnt_q != 4'h8) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
            if (scl_fall && st_q == ts_pkg::TS_HACK) begin
                bit_cnt_q  <= 4'h0;
                // high byte, then low byte padded with zeros, then wrap
                tx_q       <= nxt_w;
                lsb_next_q <= !lsb_next_q;
            end
        end
    end

    // a read address acknowledged counts as a register read
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_hit_q <= 1'b0;
        end else begin
            rd_hit_q <= scl_fall && st_q == ts_pkg::TS_DACK && rw_q;
        end
    end

    // latch the result at conversion end; bus reads never stall this
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            temp_reading <= `TS_TEMP_W'h0;
            conv_active  <= 1'b0;
        end else begin
            conv_active <= conv.busy;
            if (conv.done) temp_reading <= temp_sample;
        end
    end

    // alert state; a new trip in the clearing cycle wins over the clear
    assign shdn_rise_w = shutdown && !shdn_p_q;
    always_comb begin
        alert_d = alert_q;
        if (!alert_mode_select) begin
            if (conv.done) alert_d = trip_level;
        end else begin
            if (rd_hit_q || shdn_rise_w) alert_d = 1'b0;
            if (conv.done && limit_cross) alert_d = 1'b1;
        end
    end

    // open-drain pin: drive low whenever the line must read low
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            shdn_p_q               <= 1'b0;
            alert_q                <= 1'b0;
            over_temp_alert_output <= 1'b0;
            over_temp_alert_oe     <= 1'b0;
            sda_o                  <= 1'b0;
        end else begin
            shdn_p_q               <= shutdown;
            alert_q                <= alert_d;
            over_temp_alert_output <= 1'b0;
            over_temp_alert_oe     <= alert_d ^ alert_polarity;
            sda_o                  <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_shdn_clear;
        shdn_rise_w && alert_mode_select && !(conv.done && limit_cross) |=> !alert_q;
    endproperty
    a_shdn_clear: assert property (p_shdn_clear) else $error("alert kept after shutdown");

    property p_lsb_next;
        st_q == ts_pkg::TS_HACK && scl_fall && lsb_next_q
            |=> tx_q == {$past(temp_reading[2:0]), 5'h0};
    endproperty
    a_lsb_next: assert property (p_lsb_next) else $error("low byte not second");

    property p_rd_bit;
        st_q == ts_pkg::TS_RD && scl_fall && bit_cnt_q != 4'h8 && !timeout_w && !start_w && !stop_w
            |=> sda_oe == !$past(tx_q[6]);
    endproperty
    a_rd_bit: assert property (p_rd_bit) else $error("read bit out of order");

    property p_nack_release;
        st_q == ts_pkg::TS_HACK && scl_fall && !host_ack_q && !timeout_w && !start_w && !stop_w
            |=> st_q == ts_pkg::TS_IDLE && !sda_oe;
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("sda held after nack");

    property p_timeout;
        timeout_w |=> st_q == ts_pkg::TS_IDLE && !sda_oe ##1 !sda_oe;
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out did not free sda");

    property p_hold_int;
        alert_mode_select && alert_q && !rd_hit_q && !shdn_rise_w |=> alert_q;
    endproperty
    a_hold_int: assert property (p_hold_int) else $error("interrupt alert dropped early");

    property p_read_clear;
        rd_hit_q && alert_mode_select && !(conv.done && limit_cross) |=> !alert_q;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear alert");

    property p_shdn_noconv;
        shutdown |=> !conv.start ##1 !conv_active;
    endproperty
    a_shdn_noconv: assert property (p_shdn_noconv) else $error("conversion in shutdown");

    property p_idle_wait;
        st_q == ts_pkg::TS_IDLE && !start_w |=> st_q == ts_pkg::TS_IDLE && !sda_oe;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("left idle without start");
endmodule

//--- dv/ts_host_model.sv
`timescale 1ns/1ps
// bus host driving open-drain scl/sda; sda_low high means the host pulls sda down
module ts_host_model #(
    parameter int HALF = 8
) (
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // idle bus: both lines released to the pull-ups
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    // sda moves two cycles after scl falls, so the filtered lines never see a false start or stop
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sda_low = ~b;
        tick(HALF - 2);
        scl = 1'b1;
        tick(HALF);
        r = sda_line;
        scl = 1'b0;
    endtask

    // also serves as a repeated start
    task automatic start_c();
        tick(2);
        sda_low = 1'b0;
        tick(HALF - 2);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask

    task automatic stop_c();
        tick(2);
        sda_low = 1'b1;
        tick(HALF - 2);
        scl = 1'b1;
        tick(HALF);
        sda_low = 1'b0;
        tick(HALF);
    endtask

    // eight data bits then the ninth bit; last high releases sda for it
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(last, ack);
    endtask
endmodule

//--- dv/temp_sensor_bus_timeout_conversion_tb_top.sv
`timescale 1ns/1ps
`include "ts_params.svh"
module temp_sensor_bus_timeout_conversion_tb_top;
    localparam int P = 200;
    localparam int C = 20;
    localparam int T = 400;

    logic                  clock;
    logic                  rst_n;
    logic                  scl;
    logic                  sda_low;
    logic                  sda_o;
    logic                  sda_oe;
    logic                  sda_line;
    logic                  shutdown;
    logic                  alert_mode_select;
    logic                  alert_polarity;
    logic [`TS_TEMP_W-1:0] temp_sample;
    logic [`TS_TEMP_W-1:0] temp_reading;
    logic                  trip_level;
    logic                  limit_cross;
    logic                  conv_active;
    logic                  alert_o;
    logic                  alert_oe;
    int                    bad_count;
    int                    num_checks;

    // wired-and with pull-up
    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

    ts_sensor #(.PERIOD_CYC(P), .CONV_CYC(C), .TIMEOUT_CYC(T)) ts_sensor_inst (
        .clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .shutdown(shutdown), .alert_mode_select(alert_mode_select), .alert_polarity(alert_polarity),
        .temp_sample(temp_sample), .trip_level(trip_level), .limit_cross(limit_cross),
        .conv_active(conv_active), .temp_reading(temp_reading),
        .over_temp_alert_output(alert_o), .over_temp_alert_oe(alert_oe));

    ts_host_model ts_host_model_inst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check_v(input logic [10:0] got, input logic [10:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic check_b(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    // bounded wait on the conversion flag
    task automatic wait_cv(input logic v);
        int k = 0;
        while (conv_active !== v && k < 3 * P) begin
            @(negedge clock);
            k++;
        end
        if (k >= 3 * P) begin
            bad_count++;
            $display("[ERR] %0t conversion wait expired", $time);
            summarize();
        end
    endtask

    task automatic rd(input int n, output logic [7:0] b0, output logic [7:0] b1, output logic ack);
        logic [7:0] d;
        logic       a;
        ts_host_model_inst.start_c();
        ts_host_model_inst.xfer({`TS_DEV_ADDR, 1'b1}, 1'b1, d, ack);
        ts_host_model_inst.xfer(8'hff, n == 1, b0, a);
        b1 = 8'hff;
        if (n == 2) ts_host_model_inst.xfer(8'hff, 1'b1, b1, a);
        ts_host_model_inst.stop_c();
    endtask

    // busy length, period and captured result
    task automatic t_conv();
        int hi = 0;
        wait_cv(1'b0);
        wait_cv(1'b1);
        for (int i = 0; i < P; i++) begin
            hi += int'(conv_active);
            @(negedge clock);
        end
        check_v(hi[10:0], C[10:0], "busy cycles");
        check_b(conv_active, 1'b1, "next start");
        check_v(temp_reading, 11'h2b3, "reading");
        $display("t_conv done");
    endtask

    task automatic t_read();
        logic [7:0] b0, b1;
        logic       ack, seen;
        rd(2, b0, b1, ack);
        check_b(ack, 1'b0, "addr ack");
        check_v({3'h0, b0}, 11'h056, "msb");
        check_v({3'h0, b1}, 11'h060, "lsb");
        rd(1, b0, b1, ack);
        check_v({3'h0, b0}, 11'h056, "single msb");
        seen = 1'b0;
        repeat (40) begin
            @(negedge clock);
            seen |= sda_oe;
        end
        check_b(seen, 1'b0, "sda released");
        rd(2, b0, b1, ack);
        check_v({3'h0, b1}, 11'h060, "lsb after single");
        $display("t_read done");
    endtask

    // interrupt-mode latch, cleared by a read, then by shutdown
    task automatic t_alert();
        logic [7:0] b0, b1;
        logic       ack;
        alert_mode_select = 1'b1;
        for (int j = 0; j < 2; j++) begin
            limit_cross = 1'b1;
            wait_cv(1'b1);
            wait_cv(1'b0);
            repeat (2) @(negedge clock);
            limit_cross = 1'b0;
            check_b(alert_oe, 1'b1, "alert set");
            if (j == 0) begin
                repeat (P + 50) @(negedge clock);
                check_b(alert_oe, 1'b1, "alert held");
                rd(1, b0, b1, ack);
                repeat (4) @(negedge clock);
                check_b(alert_oe, 1'b0, "cleared by read");
            end
        end
        shutdown = 1'b1;
        repeat (3) @(negedge clock);
        check_b(alert_oe, 1'b0, "cleared by shutdown");
        $display("t_alert done");
    endtask

    // shutdown stops conversions, the bus stays usable
    task automatic t_shdn();
        logic [7:0] b0, b1;
        logic       ack, seen;
        temp_sample = 11'h1c4;
        seen = 1'b0;
        repeat (P + 50) begin
            @(negedge clock);
            seen |= conv_active;
        end
        check_b(seen, 1'b0, "no conversion");
        rd(2, b0, b1, ack);
        check_b(ack, 1'b0, "ack in shutdown");
        check_v({3'h0, b0}, 11'h056, "old msb");
        shutdown = 1'b0;
        wait_cv(1'b1);
        wait_cv(1'b0);
        rd(2, b0, b1, ack);
        check_v({3'h0, b0}, 11'h038, "new msb");
        check_v({3'h0, b1}, 11'h080, "new lsb");
        $display("t_shdn done");
    endtask

    // host stalls with scl low while the device drives a zero
    task automatic t_tmo();
        logic [7:0] d, b1;
        logic       ack;
        ts_host_model_inst.start_c();
        ts_host_model_inst.xfer({`TS_DEV_ADDR, 1'b1}, 1'b1, d, ack);
        check_b(ack, 1'b0, "addr ack");
        repeat (300) @(negedge clock);
        check_b(sda_oe, 1'b1, "still driving");
        repeat (150) @(negedge clock);
        check_b(sda_oe, 1'b0, "released");
        ts_host_model_inst.xfer(8'hff, 1'b1, d, ack);
        check_v({3'h0, d}, 11'h0ff, "silent without start");
        ts_host_model_inst.stop_c();
        rd(2, d, b1, ack);
        check_v({3'h0, d}, 11'h038, "read after fault");
        $display("t_tmo done");
    endtask

    // comparator mode ignores reads and shutdown; writes, foreign address, mid-run reset
    task automatic t_cmp();
        logic [7:0] d, b1;
        logic       ack;
        alert_mode_select = 1'b0;
        trip_level = 1'b1;
        wait_cv(1'b1);
        wait_cv(1'b0);
        check_b(alert_oe, 1'b1, "comparator trip");
        shutdown = 1'b1;
        rd(1, d, b1, ack);
        ts_host_model_inst.start_c();
        ts_host_model_inst.xfer({`TS_DEV_ADDR, 1'b0}, 1'b1, d, ack);
        check_b(ack, 1'b0, "write addr ack");
        ts_host_model_inst.xfer(8'h5a, 1'b1, d, ack);
        check_b(ack, 1'b0, "write data ack");
        ts_host_model_inst.start_c();
        ts_host_model_inst.xfer({`TS_DEV_ADDR ^ 7'h01, 1'b1}, 1'b1, d, ack);
        check_b(ack, 1'b1, "foreign address");
        ts_host_model_inst.stop_c();
        check_b(alert_oe, 1'b1, "comparator kept");
        alert_polarity = 1'b1;
        trip_level = 1'b0;
        repeat (2) @(negedge clock);
        check_b(alert_oe, 1'b0, "active high");
        shutdown = 1'b0;
        wait_cv(1'b1);
        wait_cv(1'b0);
        check_b(alert_oe, 1'b1, "comparator released");
        check_b(alert_o, 1'b0, "alert pin value");
        check_b(sda_o, 1'b0, "sda pin value");
        rst_n = 1'b0;
        repeat (4) @(negedge clock);
        check_v(temp_reading, 11'h000, "reading after reset");
        rst_n = 1'b1;
        @(negedge clock);
        check_b(conv_active, 1'b0, "idle after reset");
        repeat (2) @(negedge clock);
        check_b(conv_active, 1'b1, "converting after reset");
        $display("t_cmp done");
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        rst_n = 1'b0;
        shutdown = 1'b0;
        alert_mode_select = 1'b0;
        alert_polarity = 1'b0;
        temp_sample = 11'h2b3;
        trip_level = 1'b0;
        limit_cross = 1'b0;
        bad_count = 0;
        num_checks = 0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        t_conv();
        t_read();
        t_alert();
        t_shdn();
        t_tmo();
        t_cmp();
        summarize();
    end
endmodule
